// ==== dv/pmh_hs_assertions.sv ====
// Handshake assertions watching the wires between both ends
`timescale 1ns/10ps
`default_nettype none
module pmh_hs_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       frame_l,
  input wire logic       irdy_l,
  input wire logic       trdy_l,
  input wire logic       devsel_l,
  input wire logic       gnt_l,
  input wire logic       int_l,
  input wire logic [3:0] cbe_l,
  input wire logic       dev_frame_oe,
  input wire logic       dev_irdy_oe,
  input wire logic       dev_ad_oe,
  input wire logic       dev_cbe_oe,
  input wire logic       dev_int_oe
);
  logic wr_q; // Direction of the device's current access
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Command bit 0 splits writes from reads, so no full decode needed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) wr_q <= 1'b0;
    else if ($fell(frame_l) && dev_frame_oe) wr_q <= cbe_l[0];
  end
  float_reset_a:
    assert property (disable iff (1'b0) !i_rst_n |=> !dev_frame_oe && !dev_irdy_oe
      && !dev_ad_oe && !dev_int_oe) else $error("Device drove the bus in reset");
  grant_start_a:
    assert property ($fell(frame_l) && dev_frame_oe |-> !$past(gnt_l))
      else $error("Access started without grant");
  addr_drive_a:
    assert property ($fell(frame_l) && dev_frame_oe |-> dev_ad_oe && dev_cbe_oe)
      else $error("Address phase not driven");
  wait_hold_a:
    assert property (!frame_l && !irdy_l && trdy_l && !devsel_l && dev_frame_oe
      |=> !frame_l && !irdy_l) else $error("Access dropped during wait");
  final_release_a:
    assert property (frame_l && !irdy_l && !trdy_l && dev_irdy_oe |=> irdy_l)
      else $error("Ready held after final phase");
  last_phase_a:
    assert property (frame_l && !irdy_l && dev_irdy_oe |=> frame_l)
      else $error("Frame asserted again inside final phase");
  frame_ready_a:
    assert property ($rose(frame_l) && dev_frame_oe |-> !irdy_l || $rose(irdy_l))
      else $error("Frame released without ready");
  write_data_a:
    assert property (!irdy_l && dev_irdy_oe && wr_q |-> dev_ad_oe)
      else $error("Write ready without data");
  read_float_a:
    assert property (!irdy_l && dev_irdy_oe && !wr_q |-> !dev_ad_oe)
      else $error("Read ready while driving data");
  devsel_abort_a:
    assert property (($fell(frame_l) && dev_frame_oe && devsel_l) ##1 devsel_l [*8]
      |-> frame_l && irdy_l) else $error("No abort without devsel");
  // Main traffic kinds seen at least once
  cover property (!irdy_l && !trdy_l && wr_q);
  cover property (!irdy_l && !trdy_l && !wr_q);
  cover property ($fell(int_l));
endmodule : pmh_hs_assertions
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench joining the device end and the host end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        i_clk     = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        start     = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] addr      = 32'h00001000;
  logic [7:0]  beats     = 8'h01;
  logic [31:0] wr_data   = 32'h00000000;
  logic [7:0]  ev        = 8'h00;
  logic [7:0]  clr       = 8'h00;
  logic [7:0]  mask      = 8'h02;
  logic        grant_en  = 1'b1;
  logic        trdy_en   = 1'b1;
  logic        devsel_en = 1'b1;
  logic        cfg_sel   = 1'b0;
  logic        wr_valid  = 1'b1;
  logic        rd_ready  = 1'b1;
  logic        busy, done, abort, beat, cfg_access, int_seen;
  logic [31:0] rd_data, host_rd;
  logic [7:0]  status;
  int          fail_count      = 0;
  int          samples_checked = 0;
  int          beat_count      = 0;
  logic        seen;
  pmh_bus_if bus ();
  pmh_dev_end pmh_dev_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus), .i_start(start),
    .i_write(write), .i_addr(addr), .i_beats(beats), .i_wr_data(wr_data), .i_wr_valid(wr_valid),
    .i_rd_ready(rd_ready), .i_irq_event(ev), .i_irq_clear(clr), .i_irq_mask(mask), .o_busy(busy),
    .o_done(done), .o_abort(abort), .o_beat(beat), .o_rd_data(rd_data),
    .o_cfg_access(cfg_access), .o_irq_status(status));
  pmh_host_end pmh_host_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
    .i_grant_en(grant_en), .i_trdy_en(trdy_en), .i_devsel_en(devsel_en), .i_cfg_sel(cfg_sel),
    .o_rd_data(host_rd), .o_int_seen(int_seen));
  pmh_hs_assertions pmh_hs_assertions_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .frame_l(bus.frame_l), .irdy_l(bus.irdy_l), .trdy_l(bus.trdy_l), .devsel_l(bus.devsel_l),
    .gnt_l(bus.gnt_l), .int_l(bus.int_l), .cbe_l(bus.cbe_l), .dev_frame_oe(bus.dev_frame_oe),
    .dev_irdy_oe(bus.dev_irdy_oe), .dev_ad_oe(bus.dev_ad_oe), .dev_cbe_oe(bus.dev_cbe_oe),
    .dev_int_oe(bus.dev_int_oe));
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  // Pulse seen at the edge after it is raised, so counts lag a cycle
  always @(posedge i_clk) if (beat === 1'b1) beat_count++;
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic start_access(input logic wr, input logic [7:0] n, input logic [31:0] d);
    @(negedge i_clk);
    write = wr;
    beats = n;
    wr_data = d;
    beat_count = 0;
    start = 1'b1;
    @(negedge i_clk);
    start = 1'b0;
  endtask : start_access
  // Waits for the end pulse and idle; next start only after busy drops
  task automatic finish_access(input logic exp_abort, input int exp_beats);
    logic ended;
    logic aborted;
    ended = 1'b0;
    aborted = 1'b0;
    for (int n = 0; n < 200 && (busy !== 1'b0 || !ended); n++) begin
      @(negedge i_clk);
      ended |= (done === 1'b1) || (abort === 1'b1);
      aborted |= (abort === 1'b1);
    end
    if (!ended || busy !== 1'b0) begin
      fail_count++;
      print_verdict();
    end
    check("abort", aborted, exp_abort);
    check("beats", beat_count, exp_beats);
  endtask : finish_access
  task automatic irq_pulse(input logic [7:0] e, input logic [7:0] c);
    @(negedge i_clk);
    ev = e;
    clr = c;
    @(negedge i_clk);
    ev = 8'h00;
    clr = 8'h00;
  endtask : irq_pulse
  initial begin
    repeat (10) @(negedge i_clk);
    check("frame_oe", bus.dev_frame_oe, 0);
    check("int_l", bus.int_l, 1);
    i_rst_n = 1'b1;
    start_access(1'b1, 8'h03, 32'hA5A50003);
    finish_access(1'b0, 3);
    check("host_rd", host_rd, 32'hA5A50003);
    // Write data late: ready must wait for it
    wr_valid = 1'b0;
    start_access(1'b1, 8'h01, 32'h5A5A0001);
    repeat (8) begin
      @(negedge i_clk);
      check("stall_irdy", bus.irdy_l, 1);
    end
    wr_valid = 1'b1;
    finish_access(1'b0, 1);
    check("host_rd", host_rd, 32'h5A5A0001);
    grant_en = 1'b0;
    start_access(1'b0, 8'h02, 32'h00000000);
    repeat (20) begin
      @(negedge i_clk);
      check("frame_l", bus.frame_l, 1);
    end
    check("req_l", bus.dev_req_l, 0);
    grant_en = 1'b1;
    finish_access(1'b0, 2);
    check("rd_data", rd_data, 32'h5A5A0001);
    // Target withholds ready; reader first has no room either
    trdy_en = 1'b0;
    rd_ready = 1'b0;
    start_access(1'b0, 8'h02, 32'h00000000);
    repeat (10) @(negedge i_clk);
    check("read_irdy", bus.irdy_l, 1);
    rd_ready = 1'b1;
    repeat (3) @(negedge i_clk);
    check("ready_irdy", bus.irdy_l, 0);
    check("wait_beats", beat_count, 0);
    trdy_en = 1'b1;
    finish_access(1'b0, 2);
    devsel_en = 1'b0;
    start_access(1'b1, 8'h02, 32'h00000011);
    finish_access(1'b1, 0);
    devsel_en = 1'b1;
    // Host issues a config cycle; device must flag it
    cfg_sel = 1'b1;
    seen = 1'b0;
    for (int n = 0; n < 50 && !seen; n++) begin
      @(negedge i_clk);
      seen = (cfg_access === 1'b1);
    end
    check("cfg_access", seen, 1);
    cfg_sel = 1'b0;
    repeat (20) @(negedge i_clk);
    irq_pulse(8'h02, 8'h00);
    check("masked_int", bus.int_l, 1);
    check("status", status, 32'h02);
    irq_pulse(8'h01, 8'h00);
    check("int_l", bus.int_l, 0);
    irq_pulse(8'h04, 8'h00);
    irq_pulse(8'h00, 8'h01);
    check("gap_int", bus.int_l, 1);
    @(negedge i_clk);
    check("rearm_int", bus.int_l, 0);
    check("status", status, 32'h06);
    irq_pulse(8'h00, 8'h04);
    check("clear_int", bus.int_l, 1);
    @(negedge i_clk);
    check("idle_int", bus.int_l, 1);
    check("status", status, 32'h02);
    // Event and clear in one cycle: the event wins
    irq_pulse(8'h01, 8'h01);
    check("set_wins", status, 32'h03);
    @(negedge i_clk);
    check("int_seen", int_seen, 1);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// ==== rtl/pmh_dev_end.sv ====
// Device end: bus master sequencer, config detect and interrupt request
//
// Contract
// - Frame asserted from start through transfers
// - Frame released before final data phase
// - Master access starts only while granted
// - Idsel marks a configuration access
// - Unmasked status bit drives interrupt active
// - Write one clears; release when none
// - Partial clear gives one-cycle release
// - Phase completes when both readies asserted
// - Write ready only with valid data
// - Read ready when data can be taken
// - Abort when no devsel in five cycles
// - All signals sampled on rising edge
// - Reset held ten cycles; outputs floated
`timescale 1ns/10ps
`default_nettype none
`include "pmh_consts.svh"
module pmh_dev_end
  import pmh_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  pmh_bus_if.dev                         bus,
  input  wire logic                      i_start,
  input  wire logic                      i_write,
  input  wire logic [31:0]               i_addr,
  input  wire logic [`PMH_BEAT_CNT_W-1:0] i_beats,
  input  wire logic [31:0]               i_wr_data,
  input  wire logic                      i_wr_valid,
  input  wire logic                      i_rd_ready,
  input  wire logic [`PMH_IRQ_W-1:0]     i_irq_event,
  input  wire logic [`PMH_IRQ_W-1:0]     i_irq_clear,
  input  wire logic [`PMH_IRQ_W-1:0]     i_irq_mask,
  output logic                           o_busy,
  output logic                           o_done,
  output logic                           o_abort,
  output logic                           o_beat,
  output logic [31:0]                    o_rd_data,
  output logic                           o_cfg_access,
  output logic [`PMH_IRQ_W-1:0]          o_irq_status
);
  pmh_mst_state_t              state_q;
  logic [`PMH_BEAT_CNT_W-1:0]  left_q;
  logic [`PMH_DEVSEL_CNT_W-1:0] wait_q;
  logic                        write_q;
  logic                        irdy_on;
  logic                        xfer;
  logic                        last;
  logic                        ready_now;

  // Ready means data present on writes, space on reads
  assign ready_now = write_q ? i_wr_valid : i_rd_ready;
  // Completion needs both readies on the edge
  assign xfer = ~bus.irdy_l & ~bus.trdy_l;
  assign last = (left_q == `PMH_ONE_BEAT);
  assign irdy_on = bus.dev_irdy_oe & ~bus.dev_irdy_o;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= PMH_IDLE;
    end else begin
      case (state_q)
        PMH_IDLE: begin
          if (i_start && i_beats != `PMH_ZERO_BEATS) state_q <= PMH_REQ;
        end
        PMH_REQ: begin
          // Begin only while grant held and bus idle
          if (!bus.gnt_l && bus.frame_l && bus.irdy_l) state_q <= PMH_ADDR;
        end
        PMH_ADDR: state_q <= PMH_DATA;
        PMH_DATA: begin
          // No devsel in five cycles aborts
          if (bus.devsel_l && wait_q == `PMH_DEVSEL_WAIT_CYC) state_q <= PMH_TURN;
          else if (xfer && last) state_q <= PMH_TURN;
        end
        PMH_TURN: state_q <= PMH_IDLE;
        default:  state_q <= PMH_IDLE;
      endcase
    end
  end

  // Beat count and direction captured at start
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      left_q  <= `PMH_ZERO_BEATS;
      write_q <= 1'b0;
    end else if (state_q == PMH_IDLE && i_start) begin
      left_q  <= i_beats;
      write_q <= i_write;
    end else if (state_q == PMH_DATA && xfer && !last) begin
      left_q  <= left_q - `PMH_ONE_BEAT;
    end
  end

  // Devsel timeout counter, cycles since address phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_q <= `PMH_ZERO_CNT;
    end else if (state_q == PMH_ADDR || !bus.devsel_l) begin
      wait_q <= `PMH_ZERO_CNT;
    end else if (state_q == PMH_DATA && wait_q != `PMH_DEVSEL_WAIT_CYC) begin
      wait_q <= wait_q + `PMH_ONE_CNT;
    end
  end

  // Frame drive; all floated in reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.dev_frame_o  <= 1'b1;
      bus.dev_frame_oe <= 1'b0;
    end else begin
      case (state_q)
        PMH_REQ: begin
          if (!bus.gnt_l && bus.frame_l && bus.irdy_l) begin
            bus.dev_frame_o  <= 1'b0;
            bus.dev_frame_oe <= 1'b1;
          end
        end
        PMH_ADDR: begin
          // Single beat: release frame with ready
          if (left_q == `PMH_ONE_BEAT && ready_now) bus.dev_frame_o <= 1'b1;
        end
        PMH_DATA: begin
          // Release alongside ready before last phase, or on devsel timeout
          if (!bus.dev_frame_o && ready_now && (irdy_on || !xfer)
              && ((xfer && left_q == `PMH_TWO_BEATS) || (!xfer && last)))
            bus.dev_frame_o <= 1'b1;
          if (bus.devsel_l && wait_q == `PMH_DEVSEL_WAIT_CYC) bus.dev_frame_o <= 1'b1;
        end
        PMH_TURN: begin
          bus.dev_frame_o  <= 1'b1;
          bus.dev_frame_oe <= 1'b0; // Driven high a cycle, then released
        end
        default: begin
          bus.dev_frame_o  <= 1'b1;
          bus.dev_frame_oe <= 1'b0;
        end
      endcase
    end
  end

  // Ready, address/data and command drive
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.dev_irdy_o  <= 1'b1;
      bus.dev_irdy_oe <= 1'b0;
      bus.dev_ad_o    <= `PMH_ZERO_WORD;
      bus.dev_ad_oe   <= 1'b0;
      bus.dev_cbe_o   <= `PMH_CBE_IDLE;
      bus.dev_cbe_oe  <= 1'b0;
    end else if (state_q == PMH_REQ && !bus.gnt_l && bus.frame_l && bus.irdy_l) begin
      bus.dev_ad_o    <= i_addr;
      bus.dev_ad_oe   <= 1'b1;
      bus.dev_cbe_o   <= write_q ? `PMH_CMD_MEM_WRITE : `PMH_CMD_MEM_READ;
      bus.dev_cbe_oe  <= 1'b1;
      bus.dev_irdy_oe <= 1'b1;
    end else if (state_q == PMH_ADDR || (state_q == PMH_DATA && !(xfer && last)
                 && !(bus.devsel_l && wait_q == `PMH_DEVSEL_WAIT_CYC))) begin
      // Write ready only with data; read ready when room
      bus.dev_irdy_o  <= ~ready_now;
      bus.dev_ad_o    <= i_wr_data;
      bus.dev_ad_oe   <= write_q;
      bus.dev_cbe_o   <= `PMH_BE_ALL;
    end else begin
      bus.dev_irdy_o  <= 1'b1;
      bus.dev_irdy_oe <= (state_q == PMH_DATA);
      bus.dev_ad_oe   <= 1'b0;
      bus.dev_cbe_o   <= `PMH_CBE_IDLE;
      bus.dev_cbe_oe  <= (state_q == PMH_DATA);
    end
  end

  // Bus request while a transfer waits
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.dev_req_l <= 1'b1;
    end else begin
      bus.dev_req_l <= ~((state_q == PMH_IDLE && i_start) || state_q == PMH_REQ);
    end
  end

  // User status, all registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_abort   <= 1'b0;
      o_beat    <= 1'b0;
      o_rd_data <= `PMH_ZERO_WORD;
    end else begin
      o_busy  <= (state_q != PMH_IDLE);
      o_done  <= (state_q == PMH_DATA) && xfer && last;
      o_abort <= (state_q == PMH_DATA) && bus.devsel_l && wait_q == `PMH_DEVSEL_WAIT_CYC;
      o_beat  <= (state_q == PMH_DATA) && xfer;
      if (state_q == PMH_DATA && xfer && !write_q) o_rd_data <= bus.ad;
    end
  end

  // Config access: idsel with a config command, no frame of ours
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cfg_access <= 1'b0;
    end else begin
      o_cfg_access <= bus.idsel && !bus.frame_l && !bus.dev_frame_oe
                      && (bus.cbe_l == `PMH_CMD_CFG_READ || bus.cbe_l == `PMH_CMD_CFG_WRITE);
    end
  end

  // Interrupt status and open-drain request
  pmh_irq_ctl u_irq (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_event  (i_irq_event),
    .i_clear  (i_irq_clear),
    .i_mask   (i_irq_mask),
    .o_status (o_irq_status),
    .o_int_oe (bus.dev_int_oe)
  );
endmodule : pmh_dev_end
`default_nettype wire

// ==== rtl/pmh_host_end.sv ====
// Host side: arbiter grant, target responder and config cycle issuer
`timescale 1ns/10ps
`default_nettype none
`include "pmh_consts.svh"
module pmh_host_end
  import pmh_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  pmh_bus_if.host          bus,
  input  wire logic        i_grant_en,
  input  wire logic        i_trdy_en,
  input  wire logic        i_devsel_en,
  input  wire logic        i_cfg_sel,
  output logic [31:0]      o_rd_data,
  output logic             o_int_seen
);
  logic        busy_q;
  logic        rd_q;
  logic        cfg_q;
  logic        cfg_done_q;
  logic        claim;
  logic [31:0] wr_word_q;

  // Grant only on request, never over our own config frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.gnt_l <= 1'b1;
    end else begin
      bus.gnt_l <= ~(i_grant_en & ~bus.dev_req_l & ~cfg_q);
    end
  end

  // One config address phase per select, idle bus only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q      <= 1'b0;
      cfg_done_q <= 1'b0;
    end else begin
      cfg_q      <= i_cfg_sel & ~cfg_q & ~cfg_done_q & bus.frame_l & bus.irdy_l
                    & bus.dev_req_l & bus.gnt_l;
      cfg_done_q <= i_cfg_sel & (cfg_done_q | cfg_q); // Re-arms when select drops
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.idsel <= 1'b0;
    end else begin
      bus.idsel <= i_cfg_sel;
    end
  end

  // Claim stays up except on the completing final phase
  assign claim = i_devsel_en & busy_q & ~(~bus.irdy_l & ~bus.trdy_l & bus.frame_l);

  // Target claims on frame start; idle bus also frees it, so an abort cannot wedge it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_q         <= 1'b0;
      rd_q           <= 1'b0;
      bus.devsel_l   <= 1'b1;
      bus.trdy_l     <= 1'b1;
      bus.host_ad_oe <= 1'b0;
    end else begin
      if (!bus.frame_l && !cfg_q) busy_q <= 1'b1;
      else if (bus.irdy_l || !bus.trdy_l) busy_q <= 1'b0;
      if (!bus.frame_l && !busy_q && !cfg_q) rd_q <= (bus.cbe_l == `PMH_CMD_MEM_READ);
      bus.devsel_l   <= ~(i_devsel_en & (busy_q | (~bus.frame_l & ~cfg_q)));
      bus.trdy_l     <= ~(claim & i_trdy_en);
      bus.host_ad_oe <= claim & i_trdy_en & rd_q; // Read word rides with ready
    end
  end

  // Target keeps last written word and returns it on reads
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_word_q <= `PMH_ZERO_WORD;
    end else if (!bus.irdy_l && !bus.trdy_l) begin
      wr_word_q <= bus.ad;
    end
  end

  // Config address phase: frame low with a config read command
  assign bus.host_ad_o     = wr_word_q;
  assign bus.host_cbe_o    = `PMH_CMD_CFG_READ;
  assign bus.host_cbe_oe   = cfg_q;
  assign bus.host_frame_o  = ~cfg_q;
  assign bus.host_frame_oe = cfg_q;
  assign bus.host_irdy_o   = 1'b1;
  assign bus.host_irdy_oe  = 1'b0;

  // Registered user view
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data  <= `PMH_ZERO_WORD;
      o_int_seen <= 1'b0;
    end else begin
      o_rd_data  <= wr_word_q;
      o_int_seen <= ~bus.int_l;
    end
  end
endmodule : pmh_host_end
`default_nettype wire

// ==== rtl/pmh_irq_ctl.sv ====
// Interrupt status, mask and request line with edge re-arm
`timescale 1ns/10ps
`default_nettype none
`include "pmh_consts.svh"
module pmh_irq_ctl
  import pmh_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`PMH_IRQ_W-1:0] i_event,
  input  wire logic [`PMH_IRQ_W-1:0] i_clear,
  input  wire logic [`PMH_IRQ_W-1:0] i_mask,
  output logic      [`PMH_IRQ_W-1:0] o_status,
  output logic                       o_int_oe
);
  logic [`PMH_IRQ_W-1:0] status_d;
  logic                  pend_now;
  logic                  partial;

  // Sticky status; a new event outranks a same-cycle clear
  assign status_d = (o_status & ~i_clear) | i_event;
  assign pend_now = |(status_d & ~i_mask);
  assign partial  = (|(o_status & i_clear & ~i_mask)) & pend_now;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status <= `PMH_ZERO_IRQ;
    end else begin
      o_status <= status_d;
    end
  end

  // Release once nothing pending; floated in reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_int_oe <= 1'b0;
    end else begin
      o_int_oe <= pend_now & ~partial; // One-cycle gap gives a fresh edge
    end
  end
endmodule : pmh_irq_ctl
`default_nettype wire

// ==== shared/pmh_bus_if.sv ====
// Bus wires between the device master end and the host side end
`timescale 1ns/10ps
`default_nettype none
interface pmh_bus_if;
  logic        dev_frame_o, dev_frame_oe;
  logic        dev_irdy_o,  dev_irdy_oe;
  logic [31:0] dev_ad_o;
  logic        dev_ad_oe;
  logic [3:0]  dev_cbe_o;
  logic        dev_cbe_oe;
  logic        dev_req_l;
  logic        dev_int_oe;
  logic        gnt_l;
  logic        idsel;
  logic        trdy_l;
  logic        devsel_l;
  logic [31:0] host_ad_o;
  logic        host_ad_oe;
  logic [3:0]  host_cbe_o;
  logic        host_cbe_oe;
  logic        host_frame_o, host_frame_oe;
  logic        host_irdy_o, host_irdy_oe;
  // Resolved wire levels, pulled up when nobody drives, except ad which reads zero
  logic        frame_l, irdy_l, int_l;
  logic [31:0] ad;
  logic [3:0]  cbe_l;
  assign frame_l = dev_frame_oe ? dev_frame_o : (host_frame_oe ? host_frame_o : 1'b1);
  assign irdy_l  = dev_irdy_oe ? dev_irdy_o : (host_irdy_oe ? host_irdy_o : 1'b1);
  assign int_l   = dev_int_oe ? 1'b0 : 1'b1;
  assign ad      = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'h00000000);
  assign cbe_l   = dev_cbe_oe ? dev_cbe_o : (host_cbe_oe ? host_cbe_o : 4'hF);
  modport dev (
    output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe, dev_ad_o, dev_ad_oe,
    output dev_cbe_o, dev_cbe_oe, dev_req_l, dev_int_oe,
    input  gnt_l, idsel, trdy_l, devsel_l, frame_l, irdy_l, ad, cbe_l
  );
  modport host (
    output gnt_l, idsel, trdy_l, devsel_l, host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe,
    output host_frame_o, host_frame_oe, host_irdy_o, host_irdy_oe,
    input  dev_req_l, frame_l, irdy_l, int_l, ad, cbe_l
  );
endinterface : pmh_bus_if
`default_nettype wire

// ==== shared/pmh_consts.svh ====
// Timing counts and field constants for the bus master handshake block
`ifndef PMH_CONSTS_SVH
`define PMH_CONSTS_SVH
`define PMH_CLK_PERIOD_NS     5
`define PMH_DEVSEL_WAIT_CYC   3'h5
`define PMH_DEVSEL_CNT_W      3
`define PMH_RST_HOLD_CYC      10
`define PMH_IRQ_W             8
`define PMH_BEAT_CNT_W        8
`define PMH_CMD_CFG_READ      4'hA
`define PMH_CMD_CFG_WRITE     4'hB
`define PMH_CMD_MEM_READ      4'h6
`define PMH_CMD_MEM_WRITE     4'h7
`define PMH_ZERO_IRQ          8'h00
`define PMH_ZERO_WORD         32'h00000000
`define PMH_ZERO_BEATS        8'h00
`define PMH_ONE_BEAT          8'h01
`define PMH_TWO_BEATS         8'h02
`define PMH_CBE_IDLE          4'hF
`define PMH_BE_ALL            4'h0
`define PMH_ZERO_CNT          3'h0
`define PMH_ONE_CNT           3'h1
`endif

// ==== shared/pmh_pkg.sv ====
// Types shared by both ends of the bus master handshake
`default_nettype none
package pmh_pkg;
  typedef enum logic [4:0] {
    PMH_IDLE = 5'h01,
    PMH_REQ  = 5'h02,
    PMH_ADDR = 5'h04,
    PMH_DATA = 5'h08,
    PMH_TURN = 5'h10
  } pmh_mst_state_t;
endpackage : pmh_pkg
`default_nettype wire
